// *** hw/tac_pkg.sv ***
// Shared constants and types for the temperature converter register bank
package tac_pkg;

  // Pointer codes that select a data register
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_OTL = 3'h3;
  localparam logic [2:0] PTR_CONV = 3'h4;
  localparam logic [2:0] PTR_CFG2 = 3'h5;

  // Widths and padding of register words
  localparam int WORD_W = 16;
  localparam int RES_W = 10;
  localparam int LIM_W = 9;
  localparam int CFG_W = 8;
  localparam int RES_PAD = WORD_W - RES_W;
  localparam int LIM_PAD = WORD_W - LIM_W;
  localparam int CFG_PAD = WORD_W - CFG_W;

  // Field positions in the operating configuration
  localparam int CFG_CH_HI = 7;
  localparam int CFG_CH_LO = 5;
  localparam int CFG_FQ_HI = 4;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_POL = 2;
  localparam int CFG_INT = 1;
  localparam int CFG_SHDN = 0;

  // Channel code of the on-chip temperature sensor
  localparam logic [2:0] CH_TEMP = 3'h0;

  // Fault queue lengths selected by the queue field
  localparam logic [1:0] FQ_SEL_1 = 2'h0;
  localparam logic [1:0] FQ_SEL_2 = 2'h1;
  localparam logic [1:0] FQ_SEL_4 = 2'h2;
  localparam logic [2:0] FQ_LEN_1 = 3'h1;
  localparam logic [2:0] FQ_LEN_2 = 3'h2;
  localparam logic [2:0] FQ_LEN_4 = 3'h4;
  localparam logic [2:0] FQ_LEN_6 = 3'h6;
  localparam logic [2:0] FAULT_MAX = 3'h7;

  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] CFG2_MASK = 8'hC0;
  localparam logic [8:0] HYST_RST = 9'h096;
  localparam logic [8:0] OTL_RST = 9'h0A0;

  // Serial bus constants
  localparam logic [3:0] ADDR_HI = 4'h9;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] BYTE_MSB = 2'h0;
  localparam logic [1:0] BYTE_LSB = 2'h1;
  localparam logic [1:0] BYTE_REST = 2'h2;

  // Link engine states, Gray coded along address, data and acknowledge
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0,
    ENG_ADDR = 3'h1,
    ENG_AACK = 3'h3,
    ENG_WRITE = 3'h2,
    ENG_WACK = 3'h6,
    ENG_READ = 3'h7,
    ENG_RACK = 3'h5
  } tac_eng_state_t;

endpackage

// *** hw/tac_link.sv ***
// Two-wire serial slave engine running on the link clock
`timescale 1ns/10ps
`default_nettype none
module tac_link (
  // Link clock and raw reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] addr_pins,
  // Written bytes toward the register domain
  output logic [7:0] wr_byte,
  output logic wr_first,
  output logic wr_tgl,
  // Read word handshake with the register domain
  output logic rd_req_tgl,
  input wire logic rd_ack_tgl,
  input wire logic [15:0] rd_word
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    tac_pkg::tac_eng_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic nack;
    logic drive_low;
    logic [1:0] rd_idx;
    logic [7:0] wr_byte;
    logic wr_first;
    logic wr_tgl;
    logic rd_req_tgl;
    logic [1:0] ack_s;
    logic [2:0] addr_lo;
  } tac_link_st_t;

  tac_link_st_t s;
  tac_link_st_t next_s;
  logic rst_meta;
  logic rst_l;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ready;
  logic [7:0] hold_byte;

  // Reset is released into this domain through two stages
  always_ff @(posedge link_clk) begin
    rst_meta <= rst_n;
    rst_l <= rst_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    // Pins are trusted only once the second and third stages agree
    next_s.scl_s = {s.scl_s[1:0], scl_in};
    next_s.sda_s = {s.sda_s[1:0], sda_in};
    if (s.scl_s[1] == s.scl_s[2]) begin
      next_s.scl_f = s.scl_s[2];
    end
    if (s.sda_s[1] == s.sda_s[2]) begin
      next_s.sda_f = s.sda_s[2];
    end
    rise = next_s.scl_f & ~s.scl_f;
    fall = ~next_s.scl_f & s.scl_f;
    start = s.scl_f & next_s.scl_f & s.sda_f & ~next_s.sda_f;
    stop = s.scl_f & next_s.scl_f & ~s.sda_f & next_s.sda_f;
    next_s.ack_s = {s.ack_s[0], rd_ack_tgl};
    next_s.addr_lo = addr_pins;
    ready = (s.ack_s[1] == s.rd_req_tgl);
    if (s.rd_idx == tac_pkg::BYTE_MSB) begin
      hold_byte = rd_word[15:8];
    end else if (s.rd_idx == tac_pkg::BYTE_LSB) begin
      hold_byte = rd_word[7:0];
    end else begin
      hold_byte = 8'h00;
    end
    if (start) begin
      next_s.st = tac_pkg::ENG_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.first = 1'b1;
      next_s.drive_low = 1'b0;
    end else if (stop) begin
      next_s.st = tac_pkg::ENG_IDLE;
      next_s.drive_low = 1'b0;
    end else begin
      case (s.st)
        tac_pkg::ENG_ADDR, tac_pkg::ENG_WRITE: begin
          if (rise) begin
            next_s.shreg = {s.shreg[6:0], next_s.sda_f};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (fall && s.bitcnt == tac_pkg::BYTE_BITS) begin
            if (s.st == tac_pkg::ENG_ADDR) begin
              if (s.shreg[7:1] == {tac_pkg::ADDR_HI, s.addr_lo}) begin
                next_s.st = tac_pkg::ENG_AACK;
                next_s.drive_low = 1'b1;
                next_s.rw = s.shreg[0];
                next_s.rd_idx = tac_pkg::BYTE_MSB;
                next_s.rd_req_tgl = s.rd_req_tgl ^ s.shreg[0];
              end else begin
                next_s.st = tac_pkg::ENG_IDLE;
              end
            end else begin
              next_s.wr_byte = s.shreg;
              next_s.wr_first = s.first;
              next_s.first = 1'b0;
              next_s.wr_tgl = ~s.wr_tgl;
              next_s.st = tac_pkg::ENG_WACK;
              next_s.drive_low = 1'b1;
            end
          end
        end
        tac_pkg::ENG_AACK: begin
          if (fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw) begin
              next_s.st = tac_pkg::ENG_READ;
              next_s.shreg = hold_byte;
              next_s.drive_low = ~hold_byte[7];
            end else begin
              next_s.st = tac_pkg::ENG_WRITE;
              next_s.drive_low = 1'b0;
            end
          end
        end
        tac_pkg::ENG_WACK: begin
          if (fall) begin
            next_s.st = tac_pkg::ENG_WRITE;
            next_s.bitcnt = 4'h0;
            next_s.drive_low = 1'b0;
          end
        end
        tac_pkg::ENG_READ: begin
          if (!ready) begin
            // Clock held low until the word has crossed over
            next_s.shreg = hold_byte;
            next_s.drive_low = ~hold_byte[7];
          end else if (rise) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else if (fall) begin
            if (s.bitcnt == tac_pkg::BYTE_BITS) begin
              next_s.drive_low = 1'b0;
              next_s.st = tac_pkg::ENG_RACK;
              if (s.rd_idx != tac_pkg::BYTE_REST) begin
                next_s.rd_idx = s.rd_idx + 2'h1;
              end
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.drive_low = ~s.shreg[6];
            end
          end
        end
        tac_pkg::ENG_RACK: begin
          if (rise) begin
            next_s.nack = next_s.sda_f;
          end else if (fall) begin
            next_s.bitcnt = 4'h0;
            if (s.nack) begin
              next_s.st = tac_pkg::ENG_IDLE;
            end else begin
              next_s.st = tac_pkg::ENG_READ;
              next_s.shreg = hold_byte;
              next_s.drive_low = ~hold_byte[7];
            end
          end
        end
        default: begin
          next_s.st = tac_pkg::ENG_IDLE;
        end
      endcase
    end
    if (!rst_l) begin
      next_s = '0;
      next_s.scl_s = 3'h7;
      next_s.sda_s = 3'h7;
      next_s.scl_f = 1'b1;
      next_s.sda_f = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    s <= next_s;
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~((s.st == tac_pkg::ENG_READ) && !ready);
  assign sda_oe_n = ~s.drive_low;
  assign wr_byte = s.wr_byte;
  assign wr_first = s.wr_first;
  assign wr_tgl = s.wr_tgl;
  assign rd_req_tgl = s.rd_req_tgl;

endmodule
`default_nettype wire

// *** hw/tac_regs.sv ***
// Register bank of the temperature converter behind its two-wire bus
//
// Behaviour
// - Pointer codes 0 to 5 select temp, config, hysteresis, limit, result, second config.
// - Temperature result is 16-bit read-only, reading in ten upper bits.
// - Temperature code is two's complement, one step per quarter degree.
// - Operating configuration is an 8-bit readable and writable register.
// - Configuration bits 7 to 5 select sensor channel or analog inputs one to four.
// - Configuration bits 4 and 3 set fault count 1, 2, 4 or 6.
// - Bit 2 sets indicator active level, bit 1 comparator or interrupt behaviour.
// - Bit 0 high shuts the device down; resets to zero.
// - Hysteresis limit is 16-bit read/write, nine upper bits two's complement.
// - Over-temperature limit is 16-bit read/write in the same nine-bit format.
// - Converter result is 16-bit read-only, straight binary in ten upper bits.
// - First written byte loads the pointer; only three low bits select.
// - All registers are reached as a slave on the two-wire bus.
`timescale 1ns/10ps
`default_nettype none
module tac_regs (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link clock
  input wire logic link_clk,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] addr_pins,
  // Converter front end
  input wire logic sample_valid,
  input wire logic [9:0] sample_code,
  output logic [2:0] conv_channel,
  output logic conv_shutdown,
  output logic [7:0] secondary_configuration,
  // Over-temperature indicator, open drain
  output logic overtemp_indicator_out,
  output logic overtemp_indicator_oe_n
);

  typedef struct packed {
    logic [7:0] pointer;
    logic [7:0] operating_configuration;
    logic [7:0] secondary_configuration;
    logic [8:0] hysteresis_limit;
    logic [8:0] overtemp_limit;
    logic [9:0] temperature_result;
    logic [9:0] converter_result;
    logic [1:0] byte_idx;
    logic [1:0] wr_s;
    logic wr_seen;
    logic [1:0] rd_s;
    logic rd_seen;
    logic [15:0] rd_hold;
    logic rd_ack_tgl;
    logic [2:0] fault_cnt;
    logic alarm;
    logic pin_low;
  } tac_regs_st_t;

  tac_regs_st_t s;
  tac_regs_st_t next_s;
  logic [7:0] link_wr_byte;
  logic link_wr_first;
  logic link_wr_tgl;
  logic link_rd_req_tgl;
  logic wr_evt;
  logic rd_evt;
  logic take;
  logic over;
  logic under;
  logic [2:0] cnt_inc;
  logic active_level;

  ////////////////////////////////////////////////////////////////////////////
  // Read word of the register the pointer selects
  function automatic logic [15:0] read_word(input tac_regs_st_t r);
    logic [2:0] sel;
    sel = r.pointer[2:0];
    if (sel == tac_pkg::PTR_TEMP) begin
      read_word = {r.temperature_result, {tac_pkg::RES_PAD{1'b0}}};
    end else if (sel == tac_pkg::PTR_CFG) begin
      read_word = {r.operating_configuration, {tac_pkg::CFG_PAD{1'b0}}};
    end else if (sel == tac_pkg::PTR_HYST) begin
      read_word = {r.hysteresis_limit, {tac_pkg::LIM_PAD{1'b0}}};
    end else if (sel == tac_pkg::PTR_OTL) begin
      read_word = {r.overtemp_limit, {tac_pkg::LIM_PAD{1'b0}}};
    end else if (sel == tac_pkg::PTR_CONV) begin
      read_word = {r.converter_result, {tac_pkg::RES_PAD{1'b0}}};
    end else if (sel == tac_pkg::PTR_CFG2) begin
      read_word = {r.secondary_configuration, {tac_pkg::CFG_PAD{1'b0}}};
    end else begin
      read_word = 16'h0000;
    end
  endfunction

  // Fault count needed before the indicator acts
  function automatic logic [2:0] queue_len(input logic [1:0] sel);
    case (sel)
      tac_pkg::FQ_SEL_1: queue_len = tac_pkg::FQ_LEN_1;
      tac_pkg::FQ_SEL_2: queue_len = tac_pkg::FQ_LEN_2;
      tac_pkg::FQ_SEL_4: queue_len = tac_pkg::FQ_LEN_4;
      default: queue_len = tac_pkg::FQ_LEN_6;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus engine on the link clock
  tac_link u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .addr_pins(addr_pins),
    .wr_byte(link_wr_byte),
    .wr_first(link_wr_first),
    .wr_tgl(link_wr_tgl),
    .rd_req_tgl(link_rd_req_tgl),
    .rd_ack_tgl(s.rd_ack_tgl),
    .rd_word(s.rd_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    // Toggles cross in two stages; the byte itself is stable by then
    next_s.wr_s = {s.wr_s[0], link_wr_tgl};
    next_s.wr_seen = s.wr_s[1];
    wr_evt = s.wr_s[1] ^ s.wr_seen;
    next_s.rd_s = {s.rd_s[0], link_rd_req_tgl};
    next_s.rd_seen = s.rd_s[1];
    rd_evt = s.rd_s[1] ^ s.rd_seen;

    // Read word is captured once per read and held while the link shifts it
    if (rd_evt) begin
      next_s.rd_hold = read_word(s);
      next_s.rd_ack_tgl = s.rd_s[1];
    end

    if (wr_evt) begin
      if (link_wr_first) begin
        next_s.pointer = link_wr_byte;
        next_s.byte_idx = tac_pkg::BYTE_MSB;
      end else begin
        if (s.byte_idx != tac_pkg::BYTE_REST) begin
          next_s.byte_idx = s.byte_idx + 2'h1;
        end
        if (s.pointer[2:0] == tac_pkg::PTR_CFG) begin
          if (s.byte_idx == tac_pkg::BYTE_MSB) begin
            next_s.operating_configuration = link_wr_byte;
          end
        end else if (s.pointer[2:0] == tac_pkg::PTR_HYST) begin
          // hysteresis upper byte then low bit
          if (s.byte_idx == tac_pkg::BYTE_MSB) begin
            next_s.hysteresis_limit[8:1] = link_wr_byte;
          end else if (s.byte_idx == tac_pkg::BYTE_LSB) begin
            next_s.hysteresis_limit[0] = link_wr_byte[7];
          end
        end else if (s.pointer[2:0] == tac_pkg::PTR_OTL) begin
          // limit upper byte then low bit
          if (s.byte_idx == tac_pkg::BYTE_MSB) begin
            next_s.overtemp_limit[8:1] = link_wr_byte;
          end else if (s.byte_idx == tac_pkg::BYTE_LSB) begin
            next_s.overtemp_limit[0] = link_wr_byte[7];
          end
        end else if (s.pointer[2:0] == tac_pkg::PTR_CFG2) begin
          if (s.byte_idx == tac_pkg::BYTE_MSB) begin
            next_s.secondary_configuration = link_wr_byte & tac_pkg::CFG2_MASK;
          end
        end
        // read-only and undefined targets keep their contents
      end
    end

    // samples are dropped while shut down
    take = sample_valid & ~s.operating_configuration[tac_pkg::CFG_SHDN];
    // compare the upper nine bits as signed half-degree codes
    over = $signed(sample_code[9:1]) >= $signed(s.overtemp_limit);
    under = $signed(sample_code[9:1]) < $signed(s.hysteresis_limit);
    cnt_inc = (s.fault_cnt == tac_pkg::FAULT_MAX) ? s.fault_cnt : s.fault_cnt + 3'h1;

    // interrupt behaviour clears on any register read
    if (rd_evt && s.operating_configuration[tac_pkg::CFG_INT]) begin
      next_s.alarm = 1'b0;
    end
    // channel selects which result the sample lands in
    if (take && conv_channel == tac_pkg::CH_TEMP) begin
      next_s.temperature_result = sample_code;
      if (over) begin
        next_s.fault_cnt = cnt_inc;
      end else begin
        next_s.fault_cnt = 3'h0;
      end
      if (under && !s.operating_configuration[tac_pkg::CFG_INT]) begin
        next_s.alarm = 1'b0;
      end
      // indicator acts once the queue fills; set wins over clear
      if (over && cnt_inc >= queue_len(
          s.operating_configuration[tac_pkg::CFG_FQ_HI:tac_pkg::CFG_FQ_LO])) begin
        next_s.alarm = 1'b1;
      end
    end else if (take) begin
      next_s.converter_result = sample_code;
    end

    // active level from polarity bit, open drain pulls low
    active_level = next_s.operating_configuration[tac_pkg::CFG_POL];
    next_s.pin_low = next_s.alarm ? ~active_level : active_level;

    if (!rst_n) begin
      next_s = '0;
      next_s.pointer = tac_pkg::PTR_RST;
      next_s.operating_configuration = tac_pkg::CFG_RST;
      next_s.secondary_configuration = tac_pkg::CFG2_RST;
      next_s.hysteresis_limit = tac_pkg::HYST_RST;
      next_s.overtemp_limit = tac_pkg::OTL_RST;
      next_s.pin_low = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign conv_channel = s.operating_configuration[tac_pkg::CFG_CH_HI:tac_pkg::CFG_CH_LO];
  assign conv_shutdown = s.operating_configuration[tac_pkg::CFG_SHDN];
  assign secondary_configuration = s.secondary_configuration;
  assign overtemp_indicator_out = 1'b0;
  assign overtemp_indicator_oe_n = ~s.pin_low;

endmodule
`default_nettype wire

// *** verif/tac_regs_asserts.sv ***
// Concurrent checks on the pins of the temperature converter register bank
`timescale 1ns/10ps
`default_nettype none
module tac_regs_asserts (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [2:0] addr_pins,
  // Converter side
  input wire logic sample_valid,
  input wire logic [9:0] sample_code,
  input wire logic [2:0] conv_channel,
  input wire logic conv_shutdown,
  input wire logic [7:0] secondary_configuration,
  input wire logic overtemp_indicator_out,
  input wire logic overtemp_indicator_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // reset defaults
  reset_vals_a: assert property ($rose(rst_n) |-> conv_channel == 3'h0 &&
    !conv_shutdown && secondary_configuration == 8'h00) else $error("reset values wrong");
  bus_release_a: assert property ($rose(rst_n) |-> sda_oe_n && scl_oe_n)
    else $error("bus not released after reset");
  cfg2_pad_a: assert property (secondary_configuration[5:0] == 6'h00)
    else $error("secondary configuration low bits set");
  drive_zero_a: assert property (!scl_out && !sda_out && !overtemp_indicator_out)
    else $error("open drain pin driven high");
  sda_setup_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data pin changed while clock high");
  stretch_start_a: assert property ($fell(scl_oe_n) |-> !$past(scl_in))
    else $error("clock stretch began while clock high");
  stretch_len_a: assert property ($fell(scl_oe_n) |-> ##[1:400] scl_oe_n)
    else $error("clock stretch too long");
  shdn_hold_a: assert property (conv_shutdown && sample_valid |->
    ##2 $stable(overtemp_indicator_oe_n) ##1 $stable(overtemp_indicator_oe_n))
    else $error("indicator moved on a sample taken in shutdown");
  ////////////////////////////////////////////////////////////////////////////////
  cover property ($fell(scl_oe_n));
  cover property ($changed(conv_channel));
  cover property ($changed(overtemp_indicator_oe_n));
  cover property ($rose(conv_shutdown));
endmodule
bind tac_regs tac_regs_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pins(addr_pins),
  .sample_valid(sample_valid), .sample_code(sample_code), .conv_channel(conv_channel),
  .conv_shutdown(conv_shutdown), .secondary_configuration(secondary_configuration),
  .overtemp_indicator_out(overtemp_indicator_out),
  .overtemp_indicator_oe_n(overtemp_indicator_oe_n));
`default_nettype wire

// *** verif/tac_mst_model.sv ***
// Behavioural two-wire bus master facing the register bank
`timescale 1ns/10ps
`default_nettype none
module tac_mst_model #(
  parameter int HALF_NS = 820
) (
  // Wire levels after the pull-ups
  input wire logic scl_wire,
  input wire logic sda_wire,
  // High means released
  output logic scl_rel,
  output logic sda_rel
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one clock pulse
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    sda_rel = b;
    #(HALF_NS / 2);
    scl_rel = 1'b1;
    // Slave may stretch; bounded so a stuck clock shows as a failure
    while (scl_wire !== 1'b1 && n < 2000) begin
      #10;
      n++;
    end
    #(HALF_NS / 2);
    r = sda_wire;
    #(HALF_NS / 2);
    scl_rel = 1'b0;
    #(HALF_NS / 2);
  endtask
  task automatic start_cond();
    sda_rel = 1'b0;
    #(HALF_NS);
    scl_rel = 1'b0;
    #(HALF_NS / 2);
  endtask
  task automatic stop_cond();
    sda_rel = 1'b0;
    #(HALF_NS / 2);
    scl_rel = 1'b1;
    #(HALF_NS);
    sda_rel = 1'b1;
    #(HALF_NS);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Master acknowledges all but the last byte of a read
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// *** verif/tac_regs_tb_top.sv ***
// Self-checking testbench of the register bank
`timescale 1ns/10ps
`default_nettype none
module tac_regs_tb_top;
  logic sys_clk;
  logic link_clk;
  logic rst_n;
  logic [2:0] addr_pins;
  logic sample_valid;
  logic [9:0] sample_code;
  logic scl_rel, sda_rel, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic conv_shutdown, ind_out, ind_n;
  logic [2:0] conv_channel;
  logic [7:0] cfg2;
  wire logic scl_w;
  wire logic sda_w;
  int num_errors = 0;
  int cmp_count = 0;
  assign scl_w = scl_rel & scl_oe_n;
  assign sda_w = sda_rel & sda_oe_n;
  tac_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_pins(addr_pins), .sample_valid(sample_valid),
    .sample_code(sample_code), .conv_channel(conv_channel), .conv_shutdown(conv_shutdown),
    .secondary_configuration(cfg2), .overtemp_indicator_out(ind_out),
    .overtemp_indicator_oe_n(ind_n));
  tac_mst_model mst (.scl_wire(scl_w), .sda_wire(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lim_word(input logic [8:0] v);
    return {v, 7'h00};
  endfunction
  function automatic logic [15:0] res_word(input logic [9:0] c);
    return {c, 6'h00};
  endfunction
  function automatic int fq_len(input logic [1:0] s);
    return (s == 2'h3) ? 6 : (1 << s);
  endfunction
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic pb(input logic [7:0] d);
    logic a;
    mst.put_byte(d, a);
    chk({15'h0000, a}, 16'h0001, "byte ack");
  endtask
  task automatic wr(input logic [2:0] ptr, input int n, input logic [15:0] d);
    mst.start_cond();
    pb({4'h9, addr_pins, 1'b0});
    pb({5'h00, ptr});
    if (n > 0) pb(d[15:8]);
    if (n > 1) pb(d[7:0]);
    mst.stop_cond();
  endtask
  task automatic rd(input logic [2:0] ptr, input int n, input logic setp, output logic [15:0] d);
    d = 16'h0000;
    if (setp) wr(ptr, 0, 16'h0000);
    mst.start_cond();
    pb({4'h9, addr_pins, 1'b1});
    mst.get_byte(n == 1, d[15:8]);
    if (n > 1) mst.get_byte(1'b1, d[7:0]);
    mst.stop_cond();
  endtask
  task automatic smp(input logic [9:0] c);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_code <= c;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (99000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    logic [15:0] d;
    logic [15:0] v;
    logic [7:0] w;
    logic [2:0] ch;
    logic [9:0] c;
    logic p0;
    logic a;
    rst_n = 1'b0;
    addr_pins = 3'h0;
    sample_valid = 1'b0;
    sample_code = 10'h000;
    void'($urandom(32'h6aa9));
    @(posedge sys_clk);
    addr_pins <= 3'($urandom);
    // Link reset needs several slow link clocks before it is released
    repeat (40) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge sys_clk);
    mst.start_cond();
    mst.put_byte({4'h9, addr_pins ^ 3'h1, 1'b0}, a);
    mst.stop_cond();
    chk({15'h0000, a}, 16'h0000, "foreign address acked");
    rd(tac_pkg::PTR_HYST, 2, 1'b1, d);
    chk(d, lim_word(tac_pkg::HYST_RST), "hysteresis reset");
    rd(tac_pkg::PTR_OTL, 2, 1'b1, d);
    chk(d, lim_word(tac_pkg::OTL_RST), "limit reset");
    v = {1'b0, 15'($urandom)};
    w = {1'b0, 7'($urandom)};
    wr(tac_pkg::PTR_OTL, 2, v);
    wr(tac_pkg::PTR_OTL, 1, {w, 8'h00});
    rd(tac_pkg::PTR_OTL, 2, 1'b0, d);
    chk(d, lim_word({w, v[7]}), "limit pairing");
    for (int q = 0; q < 4; q++) begin
      wr(tac_pkg::PTR_CFG, 1, {3'h0, q[1:0], 1'b0, q[1] & q[0], 1'b0, 8'h00});
      p0 = ind_n;
      for (int k = 1; k <= fq_len(q[1:0]); k++) begin
        smp(10'h1FF);
        chk({15'h0000, ind_n}, {15'h0000, (k < fq_len(q[1:0])) ? p0 : ~p0}, "queue");
      end
      smp(10'h200);
      // Last pass runs interrupt behaviour, where a low sample must not release
      chk({15'h0000, ind_n}, {15'h0000, (q == 3) ? ~p0 : p0}, "hysteresis clear");
    end
    wr(tac_pkg::PTR_CFG, 1, 16'h0300);
    chk({15'h0000, conv_shutdown}, 16'h0001, "shutdown");
    p0 = ind_n;
    smp(10'h1FF);
    chk({15'h0000, ind_n}, {15'h0000, p0}, "shutdown sample");
    wr(tac_pkg::PTR_TEMP, 2, 16'hAAAA);
    rd(tac_pkg::PTR_TEMP, 2, 1'b0, d);
    chk(d, res_word(10'h200), "temperature");
    // Any read releases an interrupt; with active-low sense the idle pin is released
    chk({15'h0000, ind_n}, 16'h0001, "interrupt clear");
    ch = 3'(1 + ($urandom % 4));
    wr(tac_pkg::PTR_CFG, 1, {ch, 5'h00, 8'h00});
    chk({12'h000, conv_channel, conv_shutdown}, {12'h000, ch, 1'b0}, "channel");
    c = 10'($urandom);
    smp(c);
    rd(tac_pkg::PTR_CFG, 1, 1'b0, d);
    chk(d, {ch, 5'h00, 8'h00}, "config read");
    rd(tac_pkg::PTR_CONV, 2, 1'b1, d);
    chk(d, res_word(c), "converter result");
    rd(3'h6 + 3'($urandom % 2), 2, 1'b1, d);
    chk(d, 16'h0000, "undefined pointer");
    end_sim();
  end
endmodule
`default_nettype wire
